// *** hw/nsir_pkg.sv ***
// Constants shared by the flash status, ID and reset host.
package nsir_pkg;
    localparam int CLK_NS = 50;
    localparam int T_WP_NS = 40;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_REA_NS = 40;
    localparam int REA_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_WB_NS = 100;
    localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_RCV_US = 10;
    localparam int RCV_CYC = (T_RCV_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int TMR_W = 8;

    // Command and address bytes
    localparam logic [7:0] CMD_READ1 = 8'h00;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_MSTATUS = 8'h71;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] ID_ADDR = 8'h00;
    localparam logic [7:0] MP_CODE = 8'hc0;
    localparam logic [7:0] STATUS_RESET = 8'hc0;
    localparam int ID_LEN = 4;

    // Status byte fields
    localparam int SB_FAIL = 0;
    localparam int SB_PL_LSB = 1;
    localparam int SB_PL_W = 4;
    localparam int SB_READY = 6;
    localparam int SB_WPOFF = 7;

    // APB register map
    localparam int AW = 12;
    localparam logic [AW-1:0] A_CTRL = 12'h000;
    localparam logic [AW-1:0] A_STAT = 12'h004;
    localparam logic [AW-1:0] A_ID = 12'h008;
    localparam logic [AW-1:0] A_RES = 12'h00c;
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_WP = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_PWR = 2;
    localparam int ST_RB = 3;
    localparam int ST_MP = 4;
    localparam int ST_SB_LSB = 8;
    localparam int ST_DB_LSB = 16;
    localparam int RS_VALID = 5;
    localparam int RS_WPOFF = 6;

    typedef enum logic [2:0] {
        OP_NONE, OP_STATUS, OP_MSTATUS, OP_POLL, OP_ID, OP_RESET, OP_DATA
    } nsir_op_type;
endpackage : nsir_pkg

// *** hw/nsir_timer.sv ***
// Loadable down counter used for phase and recovery waits.
`timescale 1ns/1ps
module nsir_timer #(
    parameter int W = 8,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Status
    output logic zero
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (load) begin
            next_cnt = load_val;
        end else if (cnt != '0) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= INIT;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign zero = (cnt == '0);
endmodule : nsir_timer

// *** hw/nsir_apb_regs.sv ***
// APB slave holding the host's control register and returning its status, ID and result words.
`timescale 1ns/1ps
module nsir_apb_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nsir_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Engine side
    input wire logic busy,
    input wire logic [31:0] stat_word,
    input wire logic [31:0] id_word,
    input wire logic [31:0] res_word,
    output logic start,
    output nsir_pkg::nsir_op_type op,
    output logic wp_en
);
    logic acc;
    logic hit;
    logic next_wp_en;

    assign acc = psel && penable;
    assign pready = 1'b1;
    assign hit = (paddr == nsir_pkg::A_CTRL) || (paddr == nsir_pkg::A_STAT) ||
                 (paddr == nsir_pkg::A_ID) || (paddr == nsir_pkg::A_RES);
    assign pslverr = acc && !hit;
    assign op = nsir_pkg::nsir_op_type'(pwdata[nsir_pkg::CTRL_OP_LSB +: 3]);
    // Orders arriving while busy are dropped; software polls the done bit
    assign start = acc && pwrite && (paddr == nsir_pkg::A_CTRL) && !busy &&
                   (op != nsir_pkg::OP_NONE);

    always_comb begin
        next_wp_en = wp_en;
        if (acc && pwrite && paddr == nsir_pkg::A_CTRL) begin
            next_wp_en = pwdata[nsir_pkg::CTRL_WP];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_en <= 1'b0;
        end else begin
            wp_en <= next_wp_en;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        unique case (paddr)
            nsir_pkg::A_CTRL: prdata[nsir_pkg::CTRL_WP] = wp_en;
            nsir_pkg::A_STAT: prdata = stat_word;
            nsir_pkg::A_ID: prdata = id_word;
            nsir_pkg::A_RES: prdata = res_word;
            default: prdata = 32'h0000_0000;
        endcase
    end
endmodule : nsir_apb_regs

// *** hw/nsir_host.sv ***
// Host engine for flash status read, identification and reset.
// Operation
// [RL1] Status byte appears after status command read
// [RL2] Status refreshes without strobe toggling
// [RL3] Read command needed before resuming data reads
// [RL4] Multi-plane status command reports per-plane result
// [RL5] Judge pass/fail only once ready
// [RL6] Bit 0 is total pass or fail
// [RL7] Bits 1-4 plane results; ignore under plain status
// [RL8] Bit 6 ready, bit 7 not protected
// [RL9] ID command, address zero, four bytes
// [RL10] Ignore third ID byte; fourth means multi-plane
// [RL11] ID output holds until next command
// [RL12] Reset aborts busy read, program, erase
// [RL13] Reset clears command and status registers
// [RL14] Second reset in reset state not accepted
// [RL15] Ready/busy low for reset period, then high
// [RL16] Power-up read mode; after reset wait
// [RL17] Ready/busy low during internal operations
// [RL18] Ready/busy is open drain, wire-ORed
// [RL19] Protect low at power-up, wait recovery
// [RL20] Program and erase need two-step commands
// [RL21] Dummy program holds busy only briefly
`timescale 1ns/1ps
module nsir_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [nsir_pkg::AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash strobes
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic read_strobe_n,
    output logic wp_n,
    input wire logic rb,
    // Flash data lines
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic io_oe
);
    typedef enum logic [3:0] {
        S_PWR, S_IDLE, S_CMD, S_CMD_H, S_ADR, S_ADR_H,
        S_WB, S_RB, S_RD, S_RD_H
    } nsir_state_type;

    typedef enum logic [1:0] {
        M_READ, M_STATUS, M_ID, M_RESET
    } nsir_mode_type;

    nsir_state_type state;
    nsir_state_type next_state;
    nsir_mode_type mode;
    nsir_mode_type next_mode;
    nsir_pkg::nsir_op_type op_q;
    nsir_pkg::nsir_op_type next_op_q;
    nsir_pkg::nsir_op_type req_op;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic [1:0] rd_idx;
    logic [1:0] next_rd_idx;
    logic [1:0] rd_last;
    logic [1:0] next_rd_last;
    logic [7:0] sbyte;
    logic [7:0] next_sbyte;
    logic [7:0] dbyte;
    logic [7:0] next_dbyte;
    logic [7:0] id_mem [nsir_pkg::ID_LEN];
    logic [7:0] next_id_mem [nsir_pkg::ID_LEN];
    logic [6:0] res;
    logic [6:0] next_res;
    logic done;
    logic next_done;
    logic start;
    logic busy;
    logic wp_en;
    logic ph_load;
    logic [nsir_pkg::TMR_W-1:0] ph_val;
    logic ph_zero;
    logic pwr_zero;
    logic [31:0] stat_word;
    logic [31:0] id_word;
    logic [31:0] res_word;
    logic mp_ok;

    function automatic logic [nsir_pkg::TMR_W-1:0] cyc(input int n);
        cyc = nsir_pkg::TMR_W'(n - 1);
    endfunction : cyc

    nsir_apb_regs u_regs (
        .clk(clk),
        .rst_b(rst_b),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .busy(busy),
        .stat_word(stat_word),
        .id_word(id_word),
        .res_word(res_word),
        .start(start),
        .op(req_op),
        .wp_en(wp_en)
    );

    nsir_timer #(.W(nsir_pkg::TMR_W), .INIT('0)) u_phase (
        .clk(clk),
        .rst_b(rst_b),
        .load(ph_load),
        .load_val(ph_val),
        .zero(ph_zero)
    );

    // Power-up recovery wait before the first command
    nsir_timer #(
        .W(nsir_pkg::TMR_W),
        .INIT(nsir_pkg::TMR_W'(nsir_pkg::RCV_CYC))
    ) u_power (
        .clk(clk),
        .rst_b(rst_b),
        .load(1'b0),
        .load_val('0),
        .zero(pwr_zero)
    );

    assign busy = (state != S_IDLE);
    // Fourth byte names multi-plane support; third byte is never looked at
    assign mp_ok = (id_mem[3] == nsir_pkg::MP_CODE); // [RL10]
    assign stat_word = {8'h00, dbyte, sbyte, 3'b000, mp_ok, rb,
                        (state != S_PWR), done, busy};
    assign id_word = {id_mem[3], id_mem[2], id_mem[1], id_mem[0]};
    assign res_word = {25'h0, res};

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_op_q = op_q;
        next_cmd = cmd;
        next_rd_idx = rd_idx;
        next_rd_last = rd_last;
        next_sbyte = sbyte;
        next_dbyte = dbyte;
        next_id_mem = id_mem;
        next_res = res;
        next_done = done;
        ph_load = 1'b0;
        ph_val = cyc(nsir_pkg::WP_CYC);
        unique case (state)
            S_PWR: begin
                if (pwr_zero) begin // [RL19]
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (start) begin
                    next_done = 1'b0;
                    next_op_q = req_op;
                    next_rd_idx = 2'd0;
                    next_rd_last = 2'd0;
                    ph_load = 1'b1;
                    next_state = S_CMD;
                    unique case (req_op)
                        nsir_pkg::OP_STATUS: next_cmd = nsir_pkg::CMD_STATUS; // [RL1]
                        nsir_pkg::OP_MSTATUS: next_cmd = nsir_pkg::CMD_MSTATUS; // [RL4]
                        nsir_pkg::OP_ID: begin
                            next_cmd = nsir_pkg::CMD_ID; // [RL9]
                            next_rd_last = 2'(nsir_pkg::ID_LEN - 1);
                        end
                        nsir_pkg::OP_RESET: begin
                            next_cmd = nsir_pkg::CMD_RESET; // [RL12]
                            // Repeat reset would be refused by the flash
                            if (mode == M_RESET) begin // [RL14]
                                next_state = S_IDLE;
                                next_done = 1'b1;
                            end
                        end
                        nsir_pkg::OP_POLL: begin
                            // Status output refreshes by itself
                            ph_val = cyc(nsir_pkg::REA_CYC);
                            next_state = S_RD; // [RL2]
                        end
                        nsir_pkg::OP_DATA: begin
                            next_cmd = nsir_pkg::CMD_READ1;
                            if (mode == M_READ) begin
                                ph_val = cyc(nsir_pkg::REA_CYC);
                                next_state = S_RD;
                            end else begin
                                next_state = S_CMD; // [RL3]
                            end
                        end
                        default: begin
                            next_state = S_IDLE; // [RL20]
                        end
                    endcase
                end
            end
            S_CMD: begin
                if (ph_zero) begin
                    ph_load = 1'b1;
                    next_state = S_CMD_H;
                end
            end
            S_CMD_H: begin
                if (ph_zero) begin
                    ph_load = 1'b1;
                    unique case (op_q)
                        nsir_pkg::OP_ID: begin
                            next_mode = M_ID; // [RL11]
                            next_state = S_ADR;
                        end
                        nsir_pkg::OP_RESET: begin
                            next_mode = M_RESET; // [RL16]
                            ph_val = cyc(nsir_pkg::WB_CYC);
                            next_state = S_WB;
                        end
                        nsir_pkg::OP_DATA: begin
                            next_mode = M_READ;
                            ph_val = cyc(nsir_pkg::REA_CYC);
                            next_state = S_RD;
                        end
                        default: begin
                            next_mode = M_STATUS;
                            ph_val = cyc(nsir_pkg::REA_CYC);
                            next_state = S_RD;
                        end
                    endcase
                end
            end
            S_ADR: begin
                if (ph_zero) begin
                    ph_load = 1'b1;
                    next_state = S_ADR_H;
                end
            end
            S_ADR_H: begin
                if (ph_zero) begin
                    ph_load = 1'b1;
                    ph_val = cyc(nsir_pkg::REA_CYC);
                    next_state = S_RD;
                end
            end
            S_WB: begin
                // Busy may take a short while to appear on the line
                if (ph_zero) begin
                    next_state = S_RB;
                end
            end
            S_RB: begin
                // Wired line: any device may hold it low
                if (rb) begin // [RL15] [RL17] [RL18]
                    next_sbyte = {wp_n, nsir_pkg::STATUS_RESET[6:0]}; // [RL13]
                    next_done = 1'b1;
                    next_state = S_IDLE;
                end
            end
            S_RD: begin
                if (ph_zero) begin
                    ph_load = 1'b1;
                    next_state = S_RD_H;
                    unique case (op_q)
                        nsir_pkg::OP_ID: next_id_mem[rd_idx] = io_in;
                        nsir_pkg::OP_DATA: next_dbyte = io_in;
                        default: begin
                            next_sbyte = io_in; // [RL1]
                            next_res[nsir_pkg::RS_WPOFF] = io_in[nsir_pkg::SB_WPOFF]; // [RL8]
                            next_res[nsir_pkg::RS_VALID] = io_in[nsir_pkg::SB_READY]; // [RL8]
                            // Stale pass/fail while busy is never latched into the result word
                            if (io_in[nsir_pkg::SB_READY]) begin // [RL5]
                                next_res[nsir_pkg::SB_FAIL] = io_in[nsir_pkg::SB_FAIL]; // [RL6]
                                next_res[nsir_pkg::SB_PL_LSB +: nsir_pkg::SB_PL_W] =
                                    (cmd == nsir_pkg::CMD_MSTATUS) ?
                                    io_in[nsir_pkg::SB_PL_LSB +: nsir_pkg::SB_PL_W] :
                                    4'h0; // [RL7]
                            end
                        end
                    endcase
                end
            end
            S_RD_H: begin
                if (ph_zero) begin
                    if (rd_idx == rd_last) begin
                        next_done = 1'b1;
                        next_state = S_IDLE;
                    end else begin
                        ph_load = 1'b1;
                        ph_val = cyc(nsir_pkg::REA_CYC);
                        next_rd_idx = rd_idx + 2'd1;
                        next_state = S_RD;
                    end
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_PWR;
            mode <= M_READ;
            op_q <= nsir_pkg::OP_NONE;
            cmd <= 8'h00;
            rd_idx <= 2'd0;
            rd_last <= 2'd0;
            sbyte <= 8'h00;
            dbyte <= 8'h00;
            for (int i = 0; i < nsir_pkg::ID_LEN; i++) begin
                id_mem[i] <= 8'h00;
            end
            res <= 7'h00;
            done <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            op_q <= next_op_q;
            cmd <= next_cmd;
            rd_idx <= next_rd_idx;
            rd_last <= next_rd_last;
            sbyte <= next_sbyte;
            dbyte <= next_dbyte;
            id_mem <= next_id_mem;
            res <= next_res;
            done <= next_done;
        end
    end

    // Pin drive decoded from the state
    always_comb begin
        ce_n = (state == S_PWR) || (state == S_IDLE);
        cle = (state == S_CMD) || (state == S_CMD_H);
        ale = (state == S_ADR) || (state == S_ADR_H);
        we_n = !((state == S_CMD) || (state == S_ADR));
        read_strobe_n = (state != S_RD);
        io_oe = cle || ale;
        io_out = ale ? nsir_pkg::ID_ADDR : cmd; // [RL9]
        // Writes locked out until recovery ends
        wp_n = (state != S_PWR) && wp_en; // [RL19]
    end
endmodule : nsir_host

// *** tb/nsir_host_chk.sv ***
// Checker on the flash-side pins of the status, ID and reset host.
`timescale 1ns/1ps
module nsir_host_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Flash pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    input wire logic rb,
    input wire logic [7:0] io_out,
    input wire logic io_oe
);
    logic [7:0] up_cnt;
    logic [7:0] next_up_cnt;
    logic early;
    always_comb begin
        next_up_cnt = up_cnt;
        if (up_cnt != 8'hff) next_up_cnt = up_cnt + 8'h01;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) up_cnt <= 8'h00;
        else up_cnt <= next_up_cnt;
    end
    // Two cycles of slack on the recovery edge
    assign early = up_cnt < 8'(nsir_pkg::RCV_CYC - 1);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_wp_held_low: assert property (early |-> !wp_n)
        else $error("protect released during recovery");
    a_quiet_power_up: assert property (early |-> ce_n && we_n)
        else $error("flash touched during recovery");
    a_read_bus_free: assert property (!read_strobe_n |-> !ce_n && !io_oe && !cle && !ale)
        else $error("read strobe while host drives bus");
    a_drive_needs_latch: assert property (io_oe |-> (cle || ale) && !ce_n)
        else $error("bus driven outside command or address");
    a_cmd_byte_held: assert property ($fell(we_n) |=> we_n && $stable(io_out) && $stable(cle))
        else $error("write strobe or byte not held");
    a_status_then_read: assert property (cle && !we_n && (io_out == 8'h70 || io_out == 8'h71)
        |-> ##2 !read_strobe_n)
        else $error("status command without read cycle");
    a_id_addr_zero: assert property (ale && !we_n |-> io_out == nsir_pkg::ID_ADDR)
        else $error("identification address not zero");
    a_id_four_reads: assert property (cle && !we_n && io_out == nsir_pkg::CMD_ID |-> ##4 !read_strobe_n
        ##1 read_strobe_n ##1 !read_strobe_n ##2 !read_strobe_n ##2 !read_strobe_n ##1 read_strobe_n)
        else $error("identification reads out of pattern");
    a_rst_waits_ready: assert property (cle && !we_n && io_out == nsir_pkg::CMD_RESET
        |-> ##2 (read_strobe_n && we_n && !io_oe) [*2])
        else $error("bus active during reset wait");
endmodule : nsir_host_chk
bind nsir_host nsir_host_chk u_chk (.clk(clk), .rst_b(rst_b), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .rb(rb), .io_out(io_out), .io_oe(io_oe));

// *** tb/nsir_flash_model.sv ***
// Behavioural flash device answering status, ID, reset and data reads.
`timescale 1ns/1ps
module nsir_flash_model #(
    parameter logic [7:0] MAKER = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEVICE = 8'h5a, // Arbitrary value
    parameter logic [7:0] SPARE = 8'h96,
    parameter int T_RST_NS = 2000
) (
    // Strobes
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic read_strobe_n,
    input wire logic wp_n,
    // Bus and ready line
    input wire logic [7:0] io_bus,
    output logic [7:0] io_drv,
    output logic rb_low,
    // Bench control
    input wire logic hold_busy,
    input wire logic [3:0] plane_fail,
    output int resets
);
    typedef enum logic [2:0] {M_READ, M_ST, M_MST, M_ID, M_RST} nsir_mode_type;
    nsir_mode_type mode = M_READ;
    logic rst_busy = 1'b0;
    logic aborted = 1'b0;
    logic [1:0] id_idx = 2'd0;
    logic [3:0] rd_cnt = 4'h0;
    logic [7:0] last = 8'h00;
    logic [7:0] sbyte;
    logic [7:0] drv;
    logic busy;
    event rst_go;
    initial resets = 0;
    always_comb begin
        busy = (hold_busy && !aborted) || rst_busy;
        sbyte = {wp_n, !busy, 1'b0, plane_fail & {4{!aborted}}, 1'b0};
        sbyte[0] = |sbyte[4:1];
        // Don't-care bits carry junk under the plain command
        if (mode != M_MST) sbyte[5:1] = ~sbyte[5:1];
        case (mode)
            M_ST, M_MST: drv = sbyte;
            M_ID: drv = id_idx == 2'd0 ? MAKER : id_idx == 2'd1 ? DEVICE : id_idx == 2'd2 ? SPARE : 8'hc0;
            default: drv = {4'h6, rd_cnt};
        endcase
    end
    // Released bus never keeps showing the old byte
    assign io_drv = (!ce_n && !read_strobe_n) ? drv : ~last;
    assign rb_low = busy;
    always @(posedge read_strobe_n) begin
        if (!ce_n) begin
            last <= drv;
            id_idx <= id_idx + 2'd1;
            if (mode == M_READ) rd_cnt <= rd_cnt + 4'h1;
        end
    end
    always @(posedge we_n) begin
        if (!ce_n && cle) begin
            case (io_bus)
                8'h70: mode <= M_ST;
                8'h71: mode <= M_MST;
                8'h90: mode <= M_ID;
                8'h00: mode <= M_READ;
                8'hff: if (mode != M_RST) begin
                    mode <= M_RST;
                    aborted <= 1'b1;
                    resets <= resets + 1;
                    -> rst_go;
                end
                default: ;
            endcase
        end
        if (!ce_n && ale && mode == M_ID) id_idx <= 2'd0;
    end
    always @(rst_go) begin
        rst_busy = 1'b1;
        #T_RST_NS rst_busy = 1'b0;
    end
    always @(posedge hold_busy) aborted <= 1'b0;
endmodule : nsir_flash_model

// *** tb/nand_status_id_reset_logic_bench.sv ***
// Self-checking bench for the flash status, ID and reset host.
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module nand_status_id_reset_logic_bench;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEVICE = 8'h5a; // Arbitrary value
    localparam logic [7:0] SPARE = 8'h96;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe, rb_low;
    wire logic [7:0] io_out, io_drv, io_bus;
    logic hold_busy = 1'b0;
    logic [3:0] plane_fail = 4'h0;
    int resets;
    int fails = 0;
    int compares = 0;
    logic [63:0] notes[$];
    logic [63:0] note;
    logic [31:0] rd;
    logic err;
    logic [4:0] mix;
    logic [7:0] sb;
    logic [6:0] res;
    logic [6:0] keep;
    always #25 clk = ~clk;
    // Pull-up on the shared ready line; host wins the bus when enabled
    assign io_bus = io_oe ? io_out : io_drv;
    nsir_host dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .rb(!rb_low), .io_in(io_bus), .io_out(io_out),
        .io_oe(io_oe));
    nsir_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE), .SPARE(SPARE)) u_flash (.ce_n(ce_n), .cle(cle), .ale(ale),
        .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_bus(io_bus), .io_drv(io_drv),
        .rb_low(rb_low), .hold_busy(hold_busy), .plane_fail(plane_fail), .resets(resets));
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && notes.size() > 0) begin
            note = notes.pop_front();
            if (note[63:32] != 32'h0) `CHK(prdata & note[63:32], note[31:0])
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
        if (!w) notes.push_back({m, d & m});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // The wait for the answer ends on the first edge that sees pready high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, nsir_pkg::A_STAT, 32'h0, 32'h0);
            n++;
        end while (rd[b] !== 1'b1 && n < 400);
        if (n >= 400) fails++;
    endtask : wait_bit
    task automatic op(input logic [2:0] code, input logic wp);
        apb(1'b1, nsir_pkg::A_CTRL, {23'h0, wp, 5'h0, code}, 32'h0);
        wait_bit(nsir_pkg::ST_DONE);
    endtask : op
    task automatic give_verdict();
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial begin
        #(50 * 20000);
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hb16f9066));
        keep = 7'h0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, nsir_pkg::A_STAT, 32'h9, 32'hf);
        wait_bit(nsir_pkg::ST_PWR);
        apb(1'b0, 12'h010, 32'h0, 32'hffffffff);
        `CHK(err, 1'b1)
        apb(1'b1, nsir_pkg::A_CTRL, 32'h100, 32'h0);
        apb(1'b0, nsir_pkg::A_CTRL, 32'h100, 32'hffffffff);
        for (int i = 0; i < 12; i++) begin
            mix = 5'($urandom);
            plane_fail <= mix[3:0];
            hold_busy <= mix[4];
            op(3'd1 + 3'(i[0]), i[1]);
            sb = {i[1], !mix[4], 1'b0, mix[3:0], |mix[3:0]};
            apb(1'b0, nsir_pkg::A_STAT, {16'h0, sb, 8'h0}, {16'h0, i[0] ? 8'hdf : 8'hc1, 8'h0});
            res = mix[4] ? {1'b0, 1'b0, keep[4:0]} : {i[1], 1'b1, i[0] ? mix[3:0] : 4'h0, |mix[3:0]};
            if (!mix[4]) keep = res;
            apb(1'b0, nsir_pkg::A_RES, {25'h0, res}, mix[4] ? 32'h3f : 32'h7f);
        end
        hold_busy <= 1'b1;
        op(3'd1, 1'b1);
        hold_busy <= 1'b0;
        op(3'd3, 1'b1);
        apb(1'b0, nsir_pkg::A_STAT, 32'h4000, 32'h4000);
        op(3'd6, 1'b1);
        apb(1'b0, nsir_pkg::A_STAT, 32'h600000, 32'hff0000);
        op(3'd6, 1'b1);
        apb(1'b0, nsir_pkg::A_STAT, 32'h610000, 32'hff0000);
        op(3'd4, 1'b1);
        apb(1'b0, nsir_pkg::A_ID, {8'hc0, SPARE, DEVICE, MAKER}, 32'hffffffff);
        apb(1'b0, nsir_pkg::A_STAT, 32'h10, 32'h10);
        op(3'd6, 1'b1);
        apb(1'b0, nsir_pkg::A_STAT, 32'h620000, 32'hff0000);
        hold_busy <= 1'b1;
        plane_fail <= 4'hf;
        op(3'd5, 1'b1);
        apb(1'b0, nsir_pkg::A_STAT, 32'hc008, 32'hff08);
        `CHK(resets, 1)
        op(3'd5, 1'b1);
        `CHK(resets, 1)
        op(3'd1, 1'b1);
        apb(1'b0, nsir_pkg::A_STAT, 32'hc000, 32'hc100);
        hold_busy <= 1'b0;
        give_verdict();
    end
endmodule : nand_status_id_reset_logic_bench
